//--- rtl/ctw_clock_regs.vh
`ifndef CTW_CLOCK_REGS_VH
`define CTW_CLOCK_REGS_VH

// ----------------------------------------------------------------------------
// Source select codes
// ----------------------------------------------------------------------------
`define CTW_SRC_PRIMARY   2'h0
`define CTW_SRC_LOWPOWER  2'h1
`define CTW_SRC_EXTERNAL  2'h2

// ----------------------------------------------------------------------------
// Primary oscillator frequency setting, in MHz
// ----------------------------------------------------------------------------
`define CTW_FREQ_W        6
`define CTW_FREQ_RESET    6'h18
`define CTW_FREQ_MIN      6'h03
`define CTW_FREQ_MAX      6'h30

// ----------------------------------------------------------------------------
// Dividers
// ----------------------------------------------------------------------------
`define CTW_NUM_DIV       12
`define CTW_DIV_W         16
`define CTW_ANALOG_DIV    0

// ----------------------------------------------------------------------------
// Watchdog
// ----------------------------------------------------------------------------
`define CTW_WDT_W         32
`define CTW_WDT_DEFAULT   32'h0000_1000
`define CTW_WDT_RST_W     5
`define CTW_WDT_RST_LEN   5'h10

`endif

//--- rtl/ctw_clock_tree.v
// Overview of operation
// - Choose primary, low-power or external clock as high-frequency source.
// - Switch sources only while both old and new are low; no glitches.
// - Synchronise the three oscillator pins and the source select input before any logic uses them.
// - Primary oscillator frequency setting resets to 24 MHz.
// - Frequency setting programmable 3 to 48 MHz in 1 MHz steps.
// - Derive enables synchronous to the high-frequency clock by division.
// - Twelve 16-bit dividers: eight fixed-function, four programmable logic.
// - Analog divider output leads the digital divider outputs.
// - Low-power clock keeps feeding peripherals during deep sleep.
// - Watchdog counts low-power oscillator edges, also in deep sleep.
// - Watchdog timeout without service asserts a system reset.
// - Watchdog reset sets a watchdog flag in the reset-cause record.
// - Reset-cause record survives system reset; power-on or cause_clear_i clears it.
`include "ctw_clock_regs.vh"
`default_nettype none

module ctw_clock_tree #(
    parameter [`CTW_WDT_W-1:0] WDT_TIMEOUT = `CTW_WDT_DEFAULT
) (
    // Clock and resets
    input  wire                                 clk_i,
    input  wire                                 reset_n_i,
    input  wire                                 por_n_i,
    // Oscillator pins
    input  wire                                 primary_osc_i,
    input  wire                                 low_power_osc_i,
    input  wire                                 ext_clk_i,
    // Control
    input  wire [1:0]                           src_sel_i,
    input  wire [`CTW_FREQ_W-1:0]               freq_set_i,
    input  wire                                 freq_load_i,
    input  wire                                 deep_sleep_i,
    input  wire [`CTW_NUM_DIV*`CTW_DIV_W-1:0]   div_ratio_i,
    input  wire                                 wdt_enable_i,
    input  wire                                 wdt_service_i,
    input  wire                                 cause_clear_i,
    // Clocks out
    output reg                                  high_freq_clock_o,
    output reg  [1:0]                           src_active_o,
    output reg  [`CTW_FREQ_W-1:0]               freq_mhz_o,
    output reg                                  lp_periph_clk_o,
    output reg                                  analog_en_o,
    output reg  [`CTW_NUM_DIV-1:0]              div_en_o,
    // Watchdog and reset cause
    output reg                                  wdt_reset_o,
    output reg                                  reset_cause_wdt_o
);

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    reg [1:0] rst_sync_r;
    reg [1:0] por_sync_r;
    wire      rst_n = rst_sync_r[1];
    wire      por_n = por_sync_r[1];

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    always @(posedge clk_i or negedge por_n_i) begin
        if (!por_n_i) begin
            por_sync_r <= 2'h0;
        end else begin
            por_sync_r <= {por_sync_r[0], 1'b1};
        end
    end

    // ------------------------------------------------------------------------
    // Pin synchronisers: three stages, change accepted when stages 2 and 3 agree
    // ------------------------------------------------------------------------
    wire [4:0] pin_raw = {src_sel_i, ext_clk_i, low_power_osc_i, primary_osc_i};
    reg  [4:0] pin_s1_r;
    reg  [4:0] pin_s2_r;
    reg  [4:0] pin_s3_r;
    reg  [4:0] pin_flt_r;

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_sync
            always @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    pin_s1_r[g]  <= 1'b0;
                    pin_s2_r[g]  <= 1'b0;
                    pin_s3_r[g]  <= 1'b0;
                    pin_flt_r[g] <= 1'b0;
                end else begin
                    pin_s1_r[g] <= pin_raw[g];
                    pin_s2_r[g] <= pin_s1_r[g];
                    pin_s3_r[g] <= pin_s2_r[g];
                    if (pin_s2_r[g] == pin_s3_r[g]) begin
                        pin_flt_r[g] <= pin_s3_r[g];
                    end
                end
            end
        end
    endgenerate

    wire [2:0] src_lvl = pin_flt_r[2:0];
    wire [1:0] sel_req = pin_flt_r[4:3];

    function src_level;
        input [1:0] sel;
        input [2:0] lvl;
        begin
            case (sel)
                `CTW_SRC_LOWPOWER: src_level = lvl[1];
                `CTW_SRC_EXTERNAL: src_level = lvl[2];
                default:           src_level = lvl[0];
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // Glitch-free source switch
    // ------------------------------------------------------------------------
    // The select moves only while the old and new sources are both low, so
    // no shortened high or low phase is ever passed on.
    wire sel_valid = (sel_req != 2'h3);
    wire cur_lvl   = src_level(src_active_o, src_lvl);
    wire new_lvl   = src_level(sel_req, src_lvl);
    wire hf_nxt    = cur_lvl & ~deep_sleep_i;
    reg  hf_prev_r;
    wire hf_rise   = high_freq_clock_o & ~hf_prev_r;
    reg  lp_prev_r;
    wire lp_rise   = src_lvl[1] & ~lp_prev_r;

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            src_active_o      <= `CTW_SRC_PRIMARY;
            high_freq_clock_o <= 1'b0;
            hf_prev_r         <= 1'b0;
            lp_periph_clk_o   <= 1'b0;
            lp_prev_r         <= 1'b0;
        end else begin
            if (sel_valid && sel_req != src_active_o && !cur_lvl && !new_lvl &&
                !high_freq_clock_o) begin
                src_active_o <= sel_req;
            end
            high_freq_clock_o <= hf_nxt;
            hf_prev_r         <= high_freq_clock_o;
            lp_periph_clk_o   <= src_lvl[1];
            lp_prev_r         <= src_lvl[1];
        end
    end

    // ------------------------------------------------------------------------
    // Primary oscillator frequency setting
    // ------------------------------------------------------------------------
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            freq_mhz_o <= `CTW_FREQ_RESET;
        end else if (freq_load_i) begin
            if (freq_set_i < `CTW_FREQ_MIN) begin
                freq_mhz_o <= `CTW_FREQ_MIN;
            end else if (freq_set_i > `CTW_FREQ_MAX) begin
                freq_mhz_o <= `CTW_FREQ_MAX;
            end else begin
                freq_mhz_o <= freq_set_i;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Dividers: ratio r gives one enable every r+1 high-frequency edges
    // ------------------------------------------------------------------------
    // Digital enables pass one extra stage so the analog one leads them.
    reg  [`CTW_DIV_W-1:0]   div_cnt_r [0:`CTW_NUM_DIV-1];
    reg  [`CTW_NUM_DIV-1:0] div_tick_r;

    generate
        for (g = 0; g < `CTW_NUM_DIV; g = g + 1) begin : g_div
            wire [`CTW_DIV_W-1:0] ratio = div_ratio_i[g*`CTW_DIV_W +: `CTW_DIV_W];
            always @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    div_cnt_r[g]  <= {`CTW_DIV_W{1'b0}};
                    div_tick_r[g] <= 1'b0;
                    div_en_o[g]   <= 1'b0;
                end else begin
                    div_tick_r[g] <= 1'b0;
                    if (hf_rise) begin
                        if (div_cnt_r[g] >= ratio) begin
                            div_cnt_r[g]  <= {`CTW_DIV_W{1'b0}};
                            div_tick_r[g] <= 1'b1;
                        end else begin
                            div_cnt_r[g] <= div_cnt_r[g] + 1'b1;
                        end
                    end
                    div_en_o[g] <= div_tick_r[g];
                end
            end
        end
    endgenerate

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            analog_en_o <= 1'b0;
        end else begin
            analog_en_o <= hf_rise &&
                           div_cnt_r[`CTW_ANALOG_DIV] >=
                           div_ratio_i[`CTW_ANALOG_DIV*`CTW_DIV_W +: `CTW_DIV_W];
        end
    end

    // ------------------------------------------------------------------------
    // Watchdog on low-power oscillator edges
    // ------------------------------------------------------------------------
    reg [`CTW_WDT_W-1:0]    wdt_cnt_r;
    reg [`CTW_WDT_RST_W-1:0] wdt_rst_cnt_r;
    wire                    wdt_fire = wdt_enable_i && lp_rise && !wdt_service_i &&
                                       (wdt_cnt_r >= WDT_TIMEOUT - 1'b1);

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wdt_cnt_r     <= {`CTW_WDT_W{1'b0}};
            wdt_rst_cnt_r <= {`CTW_WDT_RST_W{1'b0}};
            wdt_reset_o   <= 1'b0;
        end else begin
            if (!wdt_enable_i || wdt_service_i || wdt_fire) begin
                wdt_cnt_r <= {`CTW_WDT_W{1'b0}};
            end else if (lp_rise) begin
                wdt_cnt_r <= wdt_cnt_r + 1'b1;
            end
            if (wdt_fire) begin
                wdt_rst_cnt_r <= `CTW_WDT_RST_LEN;
                wdt_reset_o   <= 1'b1;
            end else if (wdt_rst_cnt_r != {`CTW_WDT_RST_W{1'b0}}) begin
                wdt_rst_cnt_r <= wdt_rst_cnt_r - 1'b1;
                wdt_reset_o   <= (wdt_rst_cnt_r != {{(`CTW_WDT_RST_W-1){1'b0}}, 1'b1});
            end else begin
                wdt_reset_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Reset cause: on the power-on reset only, so a watchdog reset keeps it
    // ------------------------------------------------------------------------
    always @(posedge clk_i or negedge por_n) begin
        if (!por_n) begin
            reset_cause_wdt_o <= 1'b0;
        end else if (wdt_reset_o) begin
            reset_cause_wdt_o <= 1'b1;
        end else if (cause_clear_i) begin
            reset_cause_wdt_o <= 1'b0;
        end
    end

endmodule // ctw_clock_tree

`default_nettype wire

//--- sim/ctw_clock_tree_assertions.sv
`include "ctw_clock_regs.vh"
`default_nettype none
// --------------------------------------------------------------
// Port checks of the clock tree
// --------------------------------------------------------------
module ctw_clock_tree_chk #(
    parameter [`CTW_WDT_W-1:0] WDT_TIMEOUT = `CTW_WDT_DEFAULT
) (
    input wire logic                    clk_i,
    input wire logic                    reset_n_i,
    input wire logic                    por_n_i,
    input wire logic [`CTW_FREQ_W-1:0]  freq_set_i,
    input wire logic                    freq_load_i,
    input wire logic                    deep_sleep_i,
    input wire logic                    cause_clear_i,
    input wire logic                    high_freq_clock_o,
    input wire logic [1:0]              src_active_o,
    input wire logic [`CTW_FREQ_W-1:0]  freq_mhz_o,
    input wire logic                    analog_en_o,
    input wire logic [`CTW_NUM_DIV-1:0] div_en_o,
    input wire logic                    wdt_reset_o,
    input wire logic                    reset_cause_wdt_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] rst_len_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Length of the current watchdog reset pulse
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            rst_len_r <= 5'h00;
        else
            rst_len_r <= wdt_reset_o ? rst_len_r + 5'h01 : 5'h00;
    end
    sequence s_tick;
        analog_en_o ##1 div_en_o[0];
    endsequence
    a_analog_leads: assert property (analog_en_o |-> s_tick)
        else $error("analog tick without divider tick");
    a_freq_load: assert property (freq_load_i |=> freq_mhz_o ==
        ($past(freq_set_i) < `CTW_FREQ_MIN ? `CTW_FREQ_MIN :
        ($past(freq_set_i) > `CTW_FREQ_MAX ? `CTW_FREQ_MAX : $past(freq_set_i))))
        else $error("frequency setting wrong");
    a_src_glitch: assert property ($changed(src_active_o) |-> !$past(high_freq_clock_o))
        else $error("source switched while clock high");
    a_src_legal: assert property (src_active_o != 2'h3)
        else $error("illegal active source");
    a_sleep_gate: assert property (deep_sleep_i [*6] |-> !high_freq_clock_o)
        else $error("clock runs in deep sleep");
    a_wdt_len: assert property ($fell(wdt_reset_o) |-> rst_len_r == 5'h10)
        else $error("watchdog reset length wrong");
    a_cause_set: assert property (disable iff (!por_n_i)
        $rose(wdt_reset_o) |=> reset_cause_wdt_o) else $error("cause not set");
    a_cause_keep: assert property (disable iff (!por_n_i)
        reset_cause_wdt_o && !cause_clear_i |=> reset_cause_wdt_o) else $error("cause lost");
    a_cause_clr: assert property (disable iff (!por_n_i)
        cause_clear_i && !wdt_reset_o |=> !reset_cause_wdt_o) else $error("cause not cleared");
endmodule // ctw_clock_tree_chk
bind ctw_clock_tree ctw_clock_tree_chk #(.WDT_TIMEOUT(WDT_TIMEOUT)) u_chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .por_n_i(por_n_i), .freq_set_i(freq_set_i),
    .freq_load_i(freq_load_i), .deep_sleep_i(deep_sleep_i), .cause_clear_i(cause_clear_i),
    .high_freq_clock_o(high_freq_clock_o), .src_active_o(src_active_o),
    .freq_mhz_o(freq_mhz_o), .analog_en_o(analog_en_o), .div_en_o(div_en_o),
    .wdt_reset_o(wdt_reset_o), .reset_cause_wdt_o(reset_cause_wdt_o));
`default_nettype wire

//--- sim/ctw_periph_model.sv
`default_nettype none
// --------------------------------------------------------------
// Peripheral side: spacing between divider enables
// --------------------------------------------------------------
module ctw_periph_model (
    // Clock and reset, shared with the tree as system clock
    input  wire logic         clk_i,
    input  wire logic         reset_n_i,
    // Enables in, measured spacing out
    input  wire logic [11:0]  div_en_i,
    output var  logic [191:0] gap_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] run_r [12];
    always @(posedge clk_i or negedge reset_n_i) begin
        for (int k = 0; k < 12; k++) begin
            if (!reset_n_i) begin
                run_r[k] <= 16'h0000;
                gap_o[16*k +: 16] <= 16'h0000;
            end else if (div_en_i[k]) begin
                gap_o[16*k +: 16] <= run_r[k] + 16'h0001;
                run_r[k] <= 16'h0000;
            end else begin
                run_r[k] <= run_r[k] + 16'h0001;
            end
        end
    end
endmodule // ctw_periph_model
`default_nettype wire

//--- sim/tb_clock_tree_and_watchdog.sv
`include "ctw_clock_regs.vh"
`default_nettype none
// --------------------------------------------------------------
// Self-checking bench
// --------------------------------------------------------------
module tb_clock_tree_and_watchdog;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, reset_n_i = 0, por_n_i = 0, pri = 0, lp = 0, ext = 0;
    logic load = 0, sleep = 0, en = 0, svc = 0, clr = 0, hf_any, wr_any;
    logic [1:0] sel = 2'h0, act, lp_seen;
    logic [5:0] fset = 6'h00, freq;
    logic [191:0] ratio = '0, gap;
    logic hf, lpc, an, wr, cause;
    logic [11:0] den;
    integer seed = 32'ha1f5, n_fail = 0, compares = 0, cyc = 0, i, t;
    logic [5:0] fc [6] = '{6'h00, 6'h02, 6'h03, 6'h30, 6'h31, 6'h3f};
    logic [1:0] codes [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    ctw_clock_tree #(.WDT_TIMEOUT(32'h4)) DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .por_n_i(por_n_i), .primary_osc_i(pri), .low_power_osc_i(lp), .ext_clk_i(ext),
        .src_sel_i(sel), .freq_set_i(fset), .freq_load_i(load), .deep_sleep_i(sleep),
        .div_ratio_i(ratio), .wdt_enable_i(en), .wdt_service_i(svc), .cause_clear_i(clr),
        .high_freq_clock_o(hf), .src_active_o(act), .freq_mhz_o(freq),
        .lp_periph_clk_o(lpc), .analog_en_o(an), .div_en_o(den), .wdt_reset_o(wr),
        .reset_cause_wdt_o(cause));
    ctw_periph_model u_model (.clk_i(clk_i), .reset_n_i(reset_n_i), .div_en_i(den),
        .gap_o(gap));
    always #20 clk_i = ~clk_i;
    // Oscillators: primary period 8, external 4, low-power 12 cycles
    always @(negedge clk_i) begin
        cyc <= cyc + 1;
        pri <= cyc[2];
        ext <= cyc[1];
        lp <= (cyc % 12) < 6;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [5:0] clamp(input logic [5:0] v);
        return v < 6'h03 ? 6'h03 : (v > 6'h30 ? 6'h30 : v);
    endfunction
    task automatic tally_and_finish;
        $display("Compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        n_fail++;
        tally_and_finish;
    end
    initial begin
        repeat (3) @(negedge clk_i);
        reset_n_i = 1;
        por_n_i = 1;
        repeat (3) @(negedge clk_i);
        chk(freq, `CTW_FREQ_RESET);
        for (i = 0; i < 14; i++) begin
            fset = i < 6 ? fc[i] : $random(seed);
            load = 1;
            @(negedge clk_i);
            chk(freq, clamp(fset));
        end
        load = 0;
        for (i = 1; i < 12; i++) ratio[16*i +: 16] = $random(seed) & 16'h0007;
        repeat (400) @(negedge clk_i);
        for (i = 0; i < 12; i++) chk(gap[16*i +: 16], (ratio[16*i +: 16] + 1) * 8);
        // Analog enable one cycle ahead of the digital enable of the same divider
        for (t = 0; t < 20 && an !== 1'b1; t++) @(negedge clk_i);
        chk({an, den[0]}, 2'b10);
        @(negedge clk_i);
        chk({an, den[0]}, 2'b01);
        for (i = 0; i < 4; i++) begin
            sel = codes[i];
            for (t = 0; t < 40 && act !== codes[i]; t++) @(negedge clk_i);
            chk(act, codes[i] == 2'h3 ? 2'h2 : codes[i]);
        end
        // Sleep with the watchdog serviced well inside its timeout
        {sleep, en, hf_any, wr_any, lp_seen} = 6'b110000;
        repeat (8) @(negedge clk_i);
        for (t = 0; t < 240; t++) begin
            svc = (t % 20) == 0;
            @(negedge clk_i);
            hf_any |= hf;
            wr_any |= wr;
            lp_seen[lpc] = 1'b1;
        end
        chk(hf_any, 0);
        chk(lp_seen, 2'h3);
        chk(wr_any, 0);
        svc = 0;
        for (t = 0; t < 80 && wr !== 1'b1; t++) @(negedge clk_i);
        chk(wr, 1);
        // Clear while the watchdog reset still stands: the set must win
        en = 0;
        clr = 1;
        @(negedge clk_i);
        clr = 0;
        repeat (19) @(negedge clk_i);
        chk(wr, 0);
        chk(cause, 1);
        {sleep, reset_n_i} = 2'b00;
        repeat (3) @(negedge clk_i);
        reset_n_i = 1;
        repeat (3) @(negedge clk_i);
        chk(cause, 1);
        chk(freq, `CTW_FREQ_RESET);
        clr = 1;
        @(negedge clk_i);
        clr = 0;
        @(negedge clk_i);
        chk(cause, 0);
        tally_and_finish;
    end
endmodule // tb_clock_tree_and_watchdog
`default_nettype wire
